// File: core/uup_addr_match.sv
`timescale 1ns/1ps
module uup_addr_match
    import uup_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Address register contents and permission
    input wire logic [7:0] i_addr_reg,
    input wire logic i_allow,
    // Token from the engine
    input wire logic i_tok_valid,
    input wire logic [UUP_DA_ADDR_W-1:0] i_tok_addr,
    // Hit
    output logic o_hit
);
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hit <= 1'b0;
        end else begin
            o_hit <= i_tok_valid && i_allow && i_addr_reg[UUP_DA_EN_BIT]
                && (i_addr_reg[UUP_DA_ADDR_W-1:0] == i_tok_addr);
        end
    end

    chk_hit_needs_enable: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        o_hit |-> ($past(i_addr_reg[UUP_DA_EN_BIT]) && $past(i_tok_valid)
            && $past(i_addr_reg[UUP_DA_ADDR_W-1:0]) == $past(i_tok_addr)))
        else $error("address hit without enabled matching address");
endmodule : uup_addr_match

// File: core/uup_ctrl.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Override code zero leaves upstream lines to the engine's driver.
// - Code 001 drives D+ high, D- low; 010 drives D+ low, D- high.
// - Code 011 forces SE0; code 100 drives both lines low.
// - 101 floats D+, D- low; 110 D+ low, D- floats; 111 floats both.
// - Any non-idle upstream event sets a sticky activity flag; only hardware sets it.
// - Writing zero clears the activity flag; writing one keeps it.
// - Two read-only bits show the live D- and D+ pin levels.
// - Status bit 7 selects FIFO sizing, bit 6 selects one or two addresses.
// - An end-of-packet is driven upstream at each frame's EOF1 point while override code is zero.
// - Two address registers, function A and function B.
// - Reset clears both address registers, address zero and disabled.
// - No response to an address until its enable bit is set.
// - At most two addresses and five endpoints, FIFOs in user RAM.
// - Layout 00: B1 D8, B0 E0, A2 E8, A1 F0, A0 F8, all 8 bytes.
// - Layout 10: B0 A8, B1 B0, A0 B8 of 8; A1 C0, A2 E0 of 32.
// - Layout 01: one address, A4 D8, A3 E0, A2 E8, A1 F0, A0 F8.
// - Layout 11: A3 A8, A4 B0, A0 B8 of 8; A1 C0, A2 E0 of 32.
// - Each FIFO byte written by the engine stalls the CPU three cycles.
// - Reset clears every stored bit of the status and control register; the two pin bits stay live.
module uup_ctrl
    import uup_pkg::*;
#(
    parameter int STALL_CYCLES = UUP_STALL_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // CPU register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // Upstream pins
    input wire logic i_up_dp,
    input wire logic i_up_dm,
    output logic o_up_dp,
    output logic o_up_dp_oe,
    output logic o_up_dm,
    output logic o_up_dm_oe,
    // Engine line driver and frame timing
    input wire logic i_sie_dp,
    input wire logic i_sie_dm,
    input wire logic i_sie_oe,
    input wire logic i_eof1,
    // Engine token address
    input wire logic i_tok_valid,
    input wire logic [UUP_DA_ADDR_W-1:0] i_tok_addr,
    output logic o_func_a_hit,
    output logic o_func_b_hit,
    // Engine FIFO writes
    input wire logic i_sie_wr_valid,
    input wire logic i_sie_func_b,
    input wire logic [2:0] i_sie_ep,
    input wire logic [4:0] i_sie_idx,
    input wire logic [7:0] i_sie_wdata,
    output logic o_sie_wr_ready,
    output logic o_cpu_stall,
    // CPU FIFO reads
    input wire logic i_fifo_rd,
    input wire logic [7:0] i_fifo_rd_addr,
    output logic [7:0] o_fifo_rdata,
    // Endpoint configuration
    output logic o_two_addr,
    output logic o_large_ep
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    localparam logic [UUP_EOP_CNT_W-1:0] SE0_LAST = UUP_EOP_CNT_W'(UUP_EOP_SE0_CYC - 1);
    localparam logic [UUP_EOP_CNT_W-1:0] J_LAST = UUP_EOP_CNT_W'(UUP_EOP_J_CYC - 1);
    localparam logic [UUP_STALL_CNT_W-1:0] STALL_LOAD = UUP_STALL_CNT_W'(STALL_CYCLES);

    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic activity;
    logic ep_mode;
    logic ep_size;
    logic [7:0] func_a_addr;
    logic [7:0] func_b_addr;
    logic status_wr;
    logic line_event;
    uup_eop_state_type eop_state;
    logic [UUP_EOP_CNT_W-1:0] eop_cnt;
    logic next_dp;
    logic next_dp_oe;
    logic next_dm;
    logic next_dm_oe;
    logic [2:0] slot;
    logic slot_ok;
    logic [7:0] slot_base;
    logic [4:0] idx_mask;
    logic sie_accept;
    logic [UUP_STALL_CNT_W-1:0] stall_cnt;
    logic [UUP_STALL_CNT_W-1:0] next_stall_cnt;

    uup_ram_if #(.ADDR_W(8), .DATA_W(8)) ram_if ();

    assign status_wr = i_reg_wr && (i_reg_addr == UUP_ADDR_STATUS);
    assign next_ctrl = status_wr ? i_reg_wdata[UUP_SC_CTRL_LSB +: 3] : ctrl;
    // Anything other than the full-speed J idle state counts as activity
    assign line_event = !(i_up_dp && !i_up_dm);

    // Status and control register
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl <= UUP_STATUS_RESET[UUP_SC_CTRL_LSB +: 3];
            ep_mode <= UUP_STATUS_RESET[UUP_SC_MODE_BIT];
            ep_size <= UUP_STATUS_RESET[UUP_SC_SIZE_BIT];
        end else if (status_wr) begin
            ctrl <= next_ctrl;
            ep_mode <= i_reg_wdata[UUP_SC_MODE_BIT];
            ep_size <= i_reg_wdata[UUP_SC_SIZE_BIT];
        end
    end

    // Sticky activity flag: a new event wins over a clearing write
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            activity <= UUP_STATUS_RESET[UUP_SC_ACT_BIT];
        end else if (line_event) begin
            activity <= 1'b1;
        end else if (status_wr && !i_reg_wdata[UUP_SC_ACT_BIT]) begin
            activity <= 1'b0;
        end
    end

    // Device address registers
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            func_a_addr <= UUP_FUNC_ADDR_RESET;
            func_b_addr <= UUP_FUNC_ADDR_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == UUP_ADDR_FUNC_A) begin
                func_a_addr <= i_reg_wdata;
            end
            if (i_reg_addr == UUP_ADDR_FUNC_B) begin
                func_b_addr <= i_reg_wdata;
            end
        end
    end

    // Read port: data stands one cycle after the strobe, unmapped reads zero
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                UUP_ADDR_FUNC_A: o_reg_rdata <= func_a_addr;
                UUP_ADDR_FUNC_B: o_reg_rdata <= func_b_addr;
                UUP_ADDR_STATUS: o_reg_rdata <= {ep_size, ep_mode, i_up_dp, i_up_dm,
                    activity, ctrl};
                default: o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // End-of-packet at EOF1: SE0 for two bit times, then J for one
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            eop_state <= UUP_EOP_IDLE;
            eop_cnt <= '0;
        end else if (next_ctrl != UUP_OVR_NONE) begin
            eop_state <= UUP_EOP_IDLE;
            eop_cnt <= '0;
        end else begin
            unique case (eop_state)
                UUP_EOP_IDLE: begin
                    if (i_eof1) begin
                        eop_state <= UUP_EOP_SE0;
                        eop_cnt <= SE0_LAST;
                    end
                end
                UUP_EOP_SE0: begin
                    if (eop_cnt == '0) begin
                        eop_state <= UUP_EOP_J;
                        eop_cnt <= J_LAST;
                    end else begin
                        eop_cnt <= eop_cnt - 1'b1;
                    end
                end
                UUP_EOP_J: begin
                    if (eop_cnt == '0) begin
                        eop_state <= UUP_EOP_IDLE;
                    end else begin
                        eop_cnt <= eop_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    // Upstream drive decode, taken from the value the register is about to hold
    always_comb begin
        next_dp = 1'b0;
        next_dm = 1'b0;
        next_dp_oe = 1'b1;
        next_dm_oe = 1'b1;
        unique case (next_ctrl)
            UUP_OVR_NONE: begin
                if (eop_state == UUP_EOP_SE0) begin
                    next_dp = 1'b0;
                end else if (eop_state == UUP_EOP_J) begin
                    next_dp = 1'b1;
                end else begin
                    next_dp = i_sie_dp;
                    next_dm = i_sie_dm;
                    next_dp_oe = i_sie_oe;
                    next_dm_oe = i_sie_oe;
                end
            end
            UUP_OVR_DP_HI: next_dp = 1'b1;
            UUP_OVR_DM_HI: next_dm = 1'b1;
            UUP_OVR_SE0, UUP_OVR_BOTH_LO: next_dp = 1'b0;
            UUP_OVR_DP_FLOAT: next_dp_oe = 1'b0;
            UUP_OVR_DM_FLOAT: next_dm_oe = 1'b0;
            UUP_OVR_FLOAT: begin
                next_dp_oe = 1'b0;
                next_dm_oe = 1'b0;
            end
        endcase
    end

    // Pins change on the same edge that loads the write, from single flops
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_up_dp <= 1'b0;
            o_up_dm <= 1'b0;
            o_up_dp_oe <= 1'b0;
            o_up_dm_oe <= 1'b0;
        end else begin
            o_up_dp <= next_dp;
            o_up_dm <= next_dm;
            o_up_dp_oe <= next_dp_oe;
            o_up_dm_oe <= next_dm_oe;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_two_addr <= 1'b1;
            o_large_ep <= 1'b0;
        end else begin
            o_two_addr <= !ep_mode;
            o_large_ep <= ep_size;
        end
    end

    // Address matching; function B exists only in two-address layouts
    uup_addr_match u_match_a (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_addr_reg(func_a_addr),
        .i_allow(1'b1),
        .i_tok_valid(i_tok_valid),
        .i_tok_addr(i_tok_addr),
        .o_hit(o_func_a_hit)
    );

    uup_addr_match u_match_b (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_addr_reg(func_b_addr),
        .i_allow(!ep_mode),
        .i_tok_valid(i_tok_valid),
        .i_tok_addr(i_tok_addr),
        .o_hit(o_func_b_hit)
    );

    // Endpoint to FIFO slot; illegal endpoints are accepted but not stored
    always_comb begin
        slot = i_sie_ep;
        slot_ok = 1'b0;
        if (ep_mode) begin
            slot_ok = (i_sie_ep < 3'(UUP_NUM_SLOTS));
        end else if (i_sie_func_b) begin
            slot = 3'(UUP_SLOTS_A_TWO) + i_sie_ep;
            slot_ok = (i_sie_ep < 3'(UUP_SLOTS_B_TWO));
        end else begin
            slot_ok = (i_sie_ep < 3'(UUP_SLOTS_A_TWO));
        end
    end

    always_comb begin
        slot_base = 8'h00;
        if (slot_ok) begin
            slot_base = UUP_FIFO_BASE[{ep_size, ep_mode}][slot];
        end
    end

    assign idx_mask = (ep_size && (slot == 3'h1 || slot == 3'h2)) ?
        UUP_LARGE_MASK : UUP_SMALL_MASK;

    assign sie_accept = i_sie_wr_valid && o_sie_wr_ready;

    assign ram_if.wr_en = sie_accept && slot_ok;
    assign ram_if.wr_addr = slot_base + {3'h0, i_sie_idx & idx_mask};
    assign ram_if.wr_data = i_sie_wdata;
    assign ram_if.rd_en = i_fifo_rd;
    assign ram_if.rd_addr = i_fifo_rd_addr;
    assign o_fifo_rdata = ram_if.rd_data;

    uup_fifo_ram #(.ADDR_W(8), .DATA_W(8)) u_ram (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .ram(ram_if.mem)
    );

    // CPU stall while the engine owns the internal data bus
    always_comb begin
        next_stall_cnt = stall_cnt;
        if (sie_accept) begin
            next_stall_cnt = STALL_LOAD;
        end else if (stall_cnt != '0) begin
            next_stall_cnt = stall_cnt - 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            stall_cnt <= '0;
            o_cpu_stall <= 1'b0;
            o_sie_wr_ready <= 1'b0;
        end else begin
            stall_cnt <= next_stall_cnt;
            o_cpu_stall <= (next_stall_cnt != '0);
            o_sie_wr_ready <= (next_stall_cnt == '0);
        end
    end

    chk_ovr_engine_drive: assert property (
        (next_ctrl == UUP_OVR_NONE && eop_state == UUP_EOP_IDLE)
        |=> (o_up_dp_oe == $past(i_sie_oe) && o_up_dp == $past(i_sie_dp)
            && o_up_dm == $past(i_sie_dm)))
        else $error("engine does not own the upstream driver");

    chk_ovr_diff_drive: assert property (
        (next_ctrl == UUP_OVR_DP_HI || next_ctrl == UUP_OVR_DM_HI)
        |=> (o_up_dp_oe && o_up_dm_oe && (o_up_dp != o_up_dm)
            && (o_up_dp == ($past(next_ctrl) == UUP_OVR_DP_HI))))
        else $error("wrong differential override drive");

    chk_ovr_both_low: assert property (
        (next_ctrl == UUP_OVR_SE0 || next_ctrl == UUP_OVR_BOTH_LO)
        |=> (o_up_dp_oe && o_up_dm_oe && !o_up_dp && !o_up_dm))
        else $error("override low state not driven");

    chk_ovr_float_pins: assert property (
        (next_ctrl inside {UUP_OVR_DP_FLOAT, UUP_OVR_DM_FLOAT, UUP_OVR_FLOAT})
        |=> ((o_up_dp_oe == ($past(next_ctrl) == UUP_OVR_DM_FLOAT))
            && (o_up_dm_oe == ($past(next_ctrl) == UUP_OVR_DP_FLOAT))
            && !o_up_dp && !o_up_dm))
        else $error("float override wrong");

    chk_act_sticky_set: assert property (
        (line_event || (activity && !(status_wr && !i_reg_wdata[UUP_SC_ACT_BIT])))
        |=> activity)
        else $error("activity flag lost or not set");

    chk_act_zero_clears: assert property (
        (status_wr && !i_reg_wdata[UUP_SC_ACT_BIT] && !line_event) |=> !activity)
        else $error("writing zero did not clear activity");

    chk_pin_readback: assert property (
        (i_reg_rd && i_reg_addr == UUP_ADDR_STATUS)
        |=> (o_reg_rdata[UUP_SC_DP_BIT] == $past(i_up_dp)
            && o_reg_rdata[UUP_SC_DM_BIT] == $past(i_up_dm)))
        else $error("pin levels not reflected in status");

    chk_eof1_se0: assert property (
        (eop_state == UUP_EOP_IDLE && i_eof1 && next_ctrl == UUP_OVR_NONE)
        ##1 (next_ctrl == UUP_OVR_NONE)
        |=> (o_up_dp_oe && o_up_dm_oe && !o_up_dp && !o_up_dm))
        else $error("no SE0 after EOF1");

    chk_single_addr_b: assert property (
        ep_mode |=> !o_func_b_hit)
        else $error("function B answered in one-address layout");

    chk_stall_length: assert property (
        $rose(o_cpu_stall) |-> o_cpu_stall[*3] ##1 !o_cpu_stall)
        else $error("CPU stall not three cycles per byte");
endmodule : uup_ctrl

// File: core/uup_fifo_ram.sv
`timescale 1ns/1ps
module uup_fifo_ram
    import uup_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Access from the controller
    uup_ram_if.mem ram
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge i_mclk) begin
        if (ram.wr_en) begin
            mem[ram.wr_addr] <= ram.wr_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ram.rd_data <= '0;
        end else if (ram.rd_en) begin
            ram.rd_data <= mem[ram.rd_addr];
        end
    end
endmodule : uup_fifo_ram

// File: pkg/uup_pkg.sv
package uup_pkg;

    // Register byte addresses on the CPU port
    localparam logic [7:0] UUP_ADDR_FUNC_A = 8'h10;
    localparam logic [7:0] UUP_ADDR_STATUS = 8'h1F;
    localparam logic [7:0] UUP_ADDR_FUNC_B = 8'h40;

    // Upstream status and control fields
    localparam int UUP_SC_CTRL_LSB = 0;
    localparam int UUP_SC_ACT_BIT = 3;
    localparam int UUP_SC_DM_BIT = 4;
    localparam int UUP_SC_DP_BIT = 5;
    localparam int UUP_SC_MODE_BIT = 6;
    localparam int UUP_SC_SIZE_BIT = 7;

    // Device address register fields
    localparam int UUP_DA_EN_BIT = 7;
    localparam int UUP_DA_ADDR_W = 7;

    // Reset values
    localparam logic [7:0] UUP_STATUS_RESET = 8'h00;
    localparam logic [7:0] UUP_FUNC_ADDR_RESET = 8'h00;

    typedef enum logic [2:0] {
        UUP_OVR_NONE = 3'h0,
        UUP_OVR_DP_HI = 3'h1,
        UUP_OVR_DM_HI = 3'h2,
        UUP_OVR_SE0 = 3'h3,
        UUP_OVR_BOTH_LO = 3'h4,
        UUP_OVR_DP_FLOAT = 3'h5,
        UUP_OVR_DM_FLOAT = 3'h6,
        UUP_OVR_FLOAT = 3'h7
    } uup_ovr_type;

    typedef enum logic [1:0] {
        UUP_EOP_IDLE,
        UUP_EOP_SE0,
        UUP_EOP_J
    } uup_eop_state_type;

    // FIFO layout: index {size bit, mode bit}, then slot.
    // Two-address slots: 0..2 function A ep 0..2, 3..4 function B ep 0..1.
    // One-address slots: function A ep 0..4.
    localparam int UUP_NUM_SLOTS = 5;
    localparam int UUP_SLOTS_A_TWO = 3;
    localparam int UUP_SLOTS_B_TWO = 2;
    localparam logic [7:0] UUP_FIFO_BASE [4][5] = '{
        '{8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD8},
        '{8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD8},
        '{8'hB8, 8'hC0, 8'hE0, 8'hA8, 8'hB0},
        '{8'hB8, 8'hC0, 8'hE0, 8'hA8, 8'hB0}
    };
    localparam logic [4:0] UUP_SMALL_MASK = 5'h07;
    localparam logic [4:0] UUP_LARGE_MASK = 5'h1F;

    // Timing
    localparam int UUP_CLK_PS = 5000;
    localparam int UUP_BIT_PS = 83333;
    localparam int UUP_EOP_SE0_BITS = 2;
    localparam int UUP_EOP_J_BITS = 1;
    localparam int UUP_EOP_SE0_CYC = (UUP_EOP_SE0_BITS * UUP_BIT_PS + UUP_CLK_PS - 1) / UUP_CLK_PS;
    localparam int UUP_EOP_J_CYC = (UUP_EOP_J_BITS * UUP_BIT_PS + UUP_CLK_PS - 1) / UUP_CLK_PS;
    localparam int UUP_EOP_CNT_W = 6;
    localparam int UUP_STALL_CYCLES = 3;
    localparam int UUP_STALL_CNT_W = 2;

endpackage : uup_pkg

// File: pkg/uup_ram_if.sv
`timescale 1ns/1ps
interface uup_ram_if #(parameter int ADDR_W = 8, parameter int DATA_W = 8);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : uup_ram_if

// File: test/test_usb_upstream_ctrl_and_addressing.sv
`timescale 1ns/1ps
module test_usb_upstream_ctrl_and_addressing;
    import uup_pkg::*;
    logic i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_sie_dp, i_sie_dm, i_sie_oe, i_eof1;
    logic i_tok_valid, i_sie_wr_valid, i_sie_func_b, i_fifo_rd;
    logic [7:0] i_reg_addr, i_reg_wdata, i_sie_wdata, i_fifo_rd_addr, o_reg_rdata, o_fifo_rdata;
    logic [UUP_DA_ADDR_W-1:0] i_tok_addr;
    logic [2:0] i_sie_ep;
    logic [4:0] i_sie_idx;
    logic [1:0] line;
    logic o_up_dp, o_up_dp_oe, o_up_dm, o_up_dm_oe, host_dp, host_dm, o_func_a_hit, o_func_b_hit;
    logic o_sie_wr_ready, o_cpu_stall, o_two_addr, o_large_ep;
    logic [31:0] seed = 32'h00009D47;
    int bad_count = 0;
    int checks = 0;
    localparam logic [7:0] BASE_S [5] = '{8'hF8, 8'hF0, 8'hE8, 8'hE0, 8'hD8};
    localparam logic [7:0] BASE_L [5] = '{8'hB8, 8'hC0, 8'hE0, 8'hA8, 8'hB0};
    // Pin level seen by both ends: the device wins where it drives
    wire logic up_dp = o_up_dp_oe ? o_up_dp : host_dp;
    wire logic up_dm = o_up_dm_oe ? o_up_dm : host_dm;
    wire logic [7:0] pins = {4'h0, o_up_dp_oe, o_up_dp, o_up_dm_oe, o_up_dm};

    uup_ctrl uup_ctrl_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_up_dp(up_dp), .i_up_dm(up_dm), .o_up_dp(o_up_dp),
        .o_up_dp_oe(o_up_dp_oe), .o_up_dm(o_up_dm), .o_up_dm_oe(o_up_dm_oe),
        .i_sie_dp(i_sie_dp), .i_sie_dm(i_sie_dm), .i_sie_oe(i_sie_oe), .i_eof1(i_eof1),
        .i_tok_valid(i_tok_valid), .i_tok_addr(i_tok_addr), .o_func_a_hit(o_func_a_hit),
        .o_func_b_hit(o_func_b_hit), .i_sie_wr_valid(i_sie_wr_valid),
        .i_sie_func_b(i_sie_func_b), .i_sie_ep(i_sie_ep), .i_sie_idx(i_sie_idx),
        .i_sie_wdata(i_sie_wdata), .o_sie_wr_ready(o_sie_wr_ready), .o_cpu_stall(o_cpu_stall),
        .i_fifo_rd(i_fifo_rd), .i_fifo_rd_addr(i_fifo_rd_addr), .o_fifo_rdata(o_fifo_rdata),
        .o_two_addr(o_two_addr), .o_large_ep(o_large_ep));
    uup_host_model uup_host_model_i (.i_mclk(i_mclk), .i_line(line), .o_dp(host_dp),
        .o_dm(host_dm));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected {dp_oe, dp, dm_oe, dm}; s is the engine's {oe, dp, dm}
    function automatic logic [3:0] ovr_exp(input logic [2:0] c, input logic [2:0] s);
        case (c)
            3'h0: return {s[2], s[1], s[2], s[0]};
            3'h1: return 4'hE;
            3'h2: return 4'hB;
            3'h3, 3'h4: return 4'hA;
            3'h5: return 4'h2;
            3'h6: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction : ovr_exp

    function automatic logic [7:0] fifo_addr(input logic big, input int sl, input logic [4:0] ix);
        if (big && (sl == 1 || sl == 2)) begin
            return BASE_L[sl] + {3'h0, ix};
        end
        return (big ? BASE_L[sl] : BASE_S[sl]) + {5'h00, ix[2:0]};
    endfunction : fifo_addr

    task automatic end_sim();
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask : rd

    task automatic tok(input logic [6:0] a, input logic ea, input logic eb);
        @(posedge i_mclk);
        i_tok_valid <= 1'b1;
        i_tok_addr <= a;
        @(posedge i_mclk);
        i_tok_valid <= 1'b0;
        #1;
        chk("hit_a", {7'h00, o_func_a_hit}, {7'h00, ea});
        chk("hit_b", {7'h00, o_func_b_hit}, {7'h00, eb});
    endtask : tok

    initial begin
        logic [7:0] d;
        logic [2:0] s;
        logic [1:0] lv;
        logic [6:0] a;
        logic [4:0] ix;
        int n;
        {i_nrst, i_reg_wr, i_reg_rd, i_sie_dp, i_sie_dm, i_sie_oe, i_eof1} = '0;
        {i_tok_valid, i_sie_wr_valid, i_sie_func_b, i_fifo_rd, i_tok_addr} = '0;
        {i_reg_addr, i_reg_wdata, i_sie_wdata, i_fifo_rd_addr, i_sie_ep, i_sie_idx} = '0;
        line = 2'b10;
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(UUP_ADDR_FUNC_A, d);
        chk("addr_a_rst", d, 8'h00);
        rd(UUP_ADDR_FUNC_B, d);
        chk("addr_b_rst", d, 8'h00);
        rd(UUP_ADDR_STATUS, d);
        chk("status_rst", d, 8'h20);
        chk("two_addr_rst", {7'h00, o_two_addr}, 8'h01);
        for (int c = 0; c < 8; c++) begin
            s = 3'(rnd());
            {i_sie_oe, i_sie_dp, i_sie_dm} <= s;
            wr(UUP_ADDR_STATUS, {5'h00, 3'(c)});
            chk("pins", pins, {4'h0, ovr_exp(3'(c), s)});
        end
        {i_sie_oe, i_sie_dp, i_sie_dm} <= 3'h0;
        for (int k = 0; k < 4; k++) begin
            lv = 2'(k) ^ 2'b10;
            line <= 2'b10;
            repeat (4) @(posedge i_mclk);
            wr(UUP_ADDR_STATUS, 8'h00);
            line <= lv;
            repeat (4) @(posedge i_mclk);
            rd(UUP_ADDR_STATUS, d);
            chk("live", {6'h00, d[5:4]}, {6'h00, lv});
            line <= 2'b10;
            repeat (4) @(posedge i_mclk);
            wr(UUP_ADDR_STATUS, 8'h08);
            rd(UUP_ADDR_STATUS, d);
            chk("act", {7'h00, d[3]}, {7'h00, lv != 2'b10});
        end
        wr(UUP_ADDR_STATUS, 8'h00);
        rd(UUP_ADDR_STATUS, d);
        chk("act_clr", {7'h00, d[3]}, 8'h00);
        a = 7'(rnd()) | 7'h01;
        wr(UUP_ADDR_FUNC_A, {1'b0, a});
        tok(a, 1'b0, 1'b0);
        wr(UUP_ADDR_FUNC_A, {1'b1, a});
        wr(UUP_ADDR_FUNC_B, {1'b1, a ^ 7'h40});
        rd(UUP_ADDR_FUNC_A, d);
        chk("addr_a", d, {1'b1, a});
        rd(UUP_ADDR_FUNC_B, d);
        chk("addr_b", d, {1'b1, a ^ 7'h40});
        tok(a, 1'b1, 1'b0);
        tok(a ^ 7'h40, 1'b0, 1'b1);
        tok(a ^ 7'h20, 1'b0, 1'b0);
        rd(8'h55, d);
        chk("unmapped", d, 8'h00);
        for (int l = 0; l < 4; l++) begin
            wr(UUP_ADDR_STATUS, {2'(l), 6'h00});
            @(posedge i_mclk);
            #1 chk("cfg", {6'h00, o_large_ep, o_two_addr}, {6'h00, l[1], !l[0]});
            if (l == 1) begin
                tok(a ^ 7'h40, 1'b0, 1'b0);
            end
            for (int sl = 0; sl < 5; sl++) begin
                ix = 5'(rnd());
                d = 8'(rnd());
                @(posedge i_mclk);
                i_sie_wr_valid <= 1'b1;
                i_sie_func_b <= !l[0] && sl > 2;
                i_sie_ep <= 3'((!l[0] && sl > 2) ? sl - 3 : sl);
                i_sie_idx <= ix;
                i_sie_wdata <= d;
                for (n = 0; n < 20; n++) begin
                    #1;
                    if (o_sie_wr_ready) break;
                    @(posedge i_mclk);
                end
                @(posedge i_mclk);
                i_sie_wr_valid <= 1'b0;
                if (n == 20) begin
                    bad_count++;
                    end_sim();
                end
                for (int k = 0; k < 3; k++) begin
                    #1 chk("stall", {7'h00, o_cpu_stall}, 8'h01);
                    @(posedge i_mclk);
                end
                #1 chk("stall_end", {6'h00, o_cpu_stall, o_sie_wr_ready}, 8'h01);
                @(posedge i_mclk);
                i_fifo_rd <= 1'b1;
                i_fifo_rd_addr <= fifo_addr(l[1], sl, ix);
                @(posedge i_mclk);
                i_fifo_rd <= 1'b0;
                #1 chk("fifo", o_fifo_rdata, d);
            end
        end
        wr(UUP_ADDR_STATUS, 8'h00);
        @(posedge i_mclk);
        i_eof1 <= 1'b1;
        @(posedge i_mclk);
        i_eof1 <= 1'b0;
        repeat (10) @(posedge i_mclk);
        #1 chk("eop_se0", pins, 8'h0A);
        repeat (UUP_EOP_SE0_CYC) @(posedge i_mclk);
        #1 chk("eop_j", pins, 8'h0E);
        repeat (UUP_EOP_J_CYC) @(posedge i_mclk);
        #1 chk("eop_end", pins, 8'h00);
        end_sim();
    end
endmodule : test_usb_upstream_ctrl_and_addressing

// File: test/uup_host_model.sv
`timescale 1ns/1ps
module uup_host_model (
    // Clock
    input wire logic i_mclk,
    // Line state asked for by the bench, {D+, D-}
    input wire logic [1:0] i_line,
    // Levels the host puts on the upstream pair
    output logic o_dp,
    output logic o_dm
);
    // Host idles at J; the bench asks for K, SE0 or SE1 to make bus activity
    always_ff @(posedge i_mclk) begin
        o_dp <= i_line[1];
        o_dm <= i_line[0];
    end
endmodule : uup_host_model
